// ---- afs_status_top.sv ----
/*
  Fault and diagnostic status registers of a four-output amplifier, read and
  written over the two-wire serial control interface the device offers.
  Assumes analog detectors arrive as asynchronous active-high levels, while
  warn_temp_select, line_driver_select and the diagnostic-active flags come
  from control logic on core_clk.
*/
// Function
// RQ1: shutdown bit low while in thermal shutdown
// RQ2: warning bit low above selected threshold
// RQ3: overvoltage bit low above lockout level
// RQ4: undervoltage bit low below lockout level
// RQ5: global overcurrent low if any output overcurrent
// RQ6: pump bit hysteresis between two comparator levels
// RQ7: global clip low while any output clips
// RQ8: per-output overcurrent latches low, holds
// RQ9: writing one or reset clears latch
// RQ10: overcurrent bits high nibble, clip low nibble
// RQ11: per-output clip bits live, unlatched
// RQ12: load-okay follows resistance above selected threshold
// RQ13: load bit low when current threshold exceeded
// RQ14: load-okay high nibble, load low nibble
// RQ15: global register bit map, bit seven zero
// RQ16: reads sample live levels, read-only writes ignored
`timescale 1ns/1ps
`default_nettype none

module afs_status_top #(
  parameter int NUM_OUT = afs_pkg::OUTS,
  parameter logic [6:0] DEV_ADDR_BASE = afs_pkg::DEV_ADDR_BASE_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  input wire logic thermal_shutdown_det,
  input wire logic [3:0] warn_above_det,
  input wire logic [1:0] warn_temp_select,
  input wire logic supply_over_det,
  input wire logic supply_under_det,
  input wire logic pump_hold_below_det,
  input wire logic pump_hold_above_det,
  input wire logic [3:0] out_overcurrent_det,
  input wire logic [3:0] out_clip_det,
  input wire logic open_load_diag_active,
  input wire logic line_driver_select,
  input wire logic [3:0] res_above_speaker_det,
  input wire logic [3:0] res_above_line_det,
  input wire logic short_load_diag_active,
  input wire logic [3:0] load_current_det,
  output logic [7:0] global_fault_status,
  output logic [7:0] output_overcurrent_clip_status,
  output logic [7:0] output_load_diag_status
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the nibble layout of the per-output registers only fits four outputs
  if (NUM_OUT != afs_pkg::OUTS) begin : g_bad_outs
    $error("afs_status_top serves exactly four outputs");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 33;
  localparam logic [SYNC_W-1:0] SYNC_RESET = {2'h3, 31'h0000_0000};

  logic [SYNC_W-1:0] sync_bus;
  logic scl_s;
  logic sda_s;
  logic [1:0] addr_sel_s;
  logic thermal_shutdown_s;
  logic [3:0] warn_above_s;
  logic supply_over_s;
  logic supply_under_s;
  logic pump_below_s;
  logic pump_above_s;
  logic [3:0] oc_s;
  logic [3:0] clip_s;
  logic [3:0] res_spk_s;
  logic [3:0] res_line_s;
  logic [3:0] cur_s;

  afs_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in({scl_in, sda_in, addr_sel, thermal_shutdown_det, warn_above_det,
               supply_over_det, supply_under_det, pump_hold_below_det,
               pump_hold_above_det, out_overcurrent_det, out_clip_det,
               res_above_speaker_det, res_above_line_det, load_current_det}),
    .sync_out(sync_bus)
  );

  assign {scl_s, sda_s, addr_sel_s, thermal_shutdown_s, warn_above_s, supply_over_s,
          supply_under_s, pump_below_s, pump_above_s, oc_s, clip_s, res_spk_s,
          res_line_s, cur_s} = sync_bus;

  // ----------------------------------------------------------------
  // status sources
  // ----------------------------------------------------------------
  logic [3:0] out_overcurrent_latched_n_reg;
  logic [3:0] out_overcurrent_latched_n_next;
  logic pump_hold_low_n_reg;
  logic pump_hold_low_n_next;
  logic wr_en;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;
  logic thermal_shutdown_n;
  logic thermal_warning_n;
  logic supply_over_n;
  logic supply_under_n;
  logic any_overcurrent_n;
  logic any_clip_n;
  logic [3:0] out_load_okay;
  logic [3:0] out_load_n;
  logic [7:0] gs_byte;
  logic [7:0] ocs_byte;
  logic [7:0] lds_byte;

  // latched overcurrent and pump hysteresis; a new event beats a clearing write
  always_comb begin
    out_overcurrent_latched_n_next = out_overcurrent_latched_n_reg;
    if (wr_en && (wr_ptr == afs_pkg::PTR_OUTPUT_OVERCURRENT_CLIP_STATUS)) begin
      out_overcurrent_latched_n_next = out_overcurrent_latched_n_reg |
        wr_data[afs_pkg::HI_LSB +: 4]; // RQ9
    end
    out_overcurrent_latched_n_next = out_overcurrent_latched_n_next & ~oc_s; // RQ8
    pump_hold_low_n_next = pump_hold_low_n_reg;
    if (pump_below_s) begin
      pump_hold_low_n_next = 1'b0; // RQ6
    end else if (pump_above_s) begin
      pump_hold_low_n_next = 1'b1; // RQ6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      out_overcurrent_latched_n_reg <= afs_pkg::OC_LATCH_RESET; // RQ9
      pump_hold_low_n_reg <= afs_pkg::PUMP_HOLD_RESET;
    end else begin
      out_overcurrent_latched_n_reg <= out_overcurrent_latched_n_next;
      pump_hold_low_n_reg <= pump_hold_low_n_next;
    end
  end

  // live indicators, all active low
  assign thermal_shutdown_n = ~thermal_shutdown_s; // RQ1
  assign thermal_warning_n = ~warn_above_s[warn_temp_select]; // RQ2
  assign supply_over_n = ~supply_over_s; // RQ3
  assign supply_under_n = ~supply_under_s; // RQ4
  // the latch holds the event, so the summary keeps showing it until cleared
  assign any_overcurrent_n = &out_overcurrent_latched_n_reg; // RQ5
  assign any_clip_n = ~|clip_s; // RQ7
  // outside a diagnostic the load fields rest at the not-asserted level
  assign out_load_okay = open_load_diag_active ?
    (line_driver_select ? res_line_s : res_spk_s) : afs_pkg::LOAD_IDLE; // RQ12
  assign out_load_n = short_load_diag_active ? ~cur_s : afs_pkg::LOAD_IDLE; // RQ13

  // register images
  always_comb begin
    gs_byte = afs_pkg::STATUS_RESET;
    gs_byte[afs_pkg::GS_UNUSED] = 1'b0; // RQ15
    gs_byte[afs_pkg::GS_THERMAL_SHUTDOWN] = thermal_shutdown_n; // RQ15
    gs_byte[afs_pkg::GS_THERMAL_WARNING] = thermal_warning_n;
    gs_byte[afs_pkg::GS_SUPPLY_OVER] = supply_over_n;
    gs_byte[afs_pkg::GS_SUPPLY_UNDER] = supply_under_n;
    gs_byte[afs_pkg::GS_ANY_OVERCURRENT] = any_overcurrent_n;
    gs_byte[afs_pkg::GS_PUMP_HOLD_LOW] = pump_hold_low_n_reg;
    gs_byte[afs_pkg::GS_ANY_CLIP] = any_clip_n;
    ocs_byte = {out_overcurrent_latched_n_reg, ~clip_s}; // RQ10 RQ11
    lds_byte = {out_load_okay, out_load_n}; // RQ14
  end

  // read decode, shared by the serial transmitter
  function automatic logic [7:0] read_mux(input logic [7:0] ptr, input logic [7:0] g,
                                          input logic [7:0] o, input logic [7:0] l);
    logic [7:0] val;
    val = afs_pkg::UNMAPPED_READ;
    unique case (ptr)
      afs_pkg::PTR_GLOBAL_FAULT_STATUS: val = g;
      afs_pkg::PTR_OUTPUT_OVERCURRENT_CLIP_STATUS: val = o;
      afs_pkg::PTR_OUTPUT_LOAD_DIAG_STATUS: val = l;
      default: val = afs_pkg::UNMAPPED_READ;
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    AFS_IDLE = 8'h01,
    AFS_ADDR = 8'h02,
    AFS_REG = 8'h04,
    AFS_WDATA = 8'h08,
    AFS_ACK_WAIT = 8'h10,
    AFS_ACK_DRIVE = 8'h20,
    AFS_TX = 8'h40,
    AFS_MACK = 8'h80
  } afs_state_t;

  afs_state_t state_reg;
  afs_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic to_tx_reg;
  logic to_tx_next;
  logic addr_phase_reg;
  logic addr_phase_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign rx_byte = {shift_reg[6:0], sda_s};
  // sampled at load time, so a read returns the level of that moment
  assign rd_byte = read_mux(ptr_reg, gs_byte, ocs_byte, lds_byte); // RQ16

  // framing, acknowledge and byte movement
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    to_tx_next = to_tx_reg;
    addr_phase_next = addr_phase_reg;
    sda_oe_next = sda_oe_reg;
    wr_en = 1'b0;
    wr_ptr = ptr_reg;
    wr_data = rx_byte;
    if (bus_start) begin
      state_next = AFS_ADDR;
      bit_cnt_next = 3'h0;
      sda_oe_next = 1'b0;
    end else if (bus_stop) begin
      state_next = AFS_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        AFS_IDLE: begin
          sda_oe_next = 1'b0;
        end
        AFS_ADDR, AFS_REG, AFS_WDATA: begin
          if (scl_rise) begin
            shift_next = rx_byte;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == afs_pkg::LAST_BIT) begin
              state_next = AFS_ACK_WAIT;
              to_tx_next = 1'b0;
              addr_phase_next = (state_reg == AFS_ADDR);
              if (state_reg == AFS_ADDR) begin
                if (rx_byte[7:1] != {DEV_ADDR_BASE[6:2], addr_sel_s}) begin
                  state_next = AFS_IDLE;
                end
                to_tx_next = (rx_byte[0] == afs_pkg::RW_READ);
              end else if (state_reg == AFS_REG) begin
                ptr_next = rx_byte;
              end else begin
                // only the latched field reacts; the rest is read-only
                wr_en = 1'b1; // RQ16
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        AFS_ACK_WAIT: begin
          if (scl_fall) begin
            sda_oe_next = 1'b1;
            state_next = AFS_ACK_DRIVE;
          end
        end
        AFS_ACK_DRIVE: begin
          if (scl_fall) begin
            bit_cnt_next = 3'h0;
            if (to_tx_reg) begin
              shift_next = rd_byte;
              sda_oe_next = ~rd_byte[7];
              state_next = AFS_TX;
            end else begin
              sda_oe_next = 1'b0;
              // the address is followed by a pointer, the pointer by data
              state_next = addr_phase_reg ? AFS_REG : AFS_WDATA;
            end
          end
        end
        AFS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == afs_pkg::LAST_BIT) begin
              sda_oe_next = 1'b0;
              state_next = AFS_MACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              sda_oe_next = ~shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 3'h1;
            end
          end
        end
        AFS_MACK: begin
          if (scl_rise) begin
            ptr_next = ptr_reg + 8'h01;
            state_next = sda_s ? AFS_IDLE : AFS_ACK_DRIVE;
          end
        end
        default: begin
          state_next = AFS_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= AFS_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= afs_pkg::PTR_RESET;
      to_tx_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      to_tx_reg <= to_tx_next;
      addr_phase_reg <= addr_phase_next;
      sda_oe_reg <= sda_oe_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // registered status mirrors
  // ----------------------------------------------------------------
  logic [7:0] gs_q_reg;
  logic [7:0] ocs_q_reg;
  logic [7:0] lds_q_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gs_q_reg <= afs_pkg::STATUS_RESET;
      ocs_q_reg <= afs_pkg::STATUS_RESET;
      lds_q_reg <= afs_pkg::STATUS_RESET;
    end else begin
      gs_q_reg <= gs_byte;
      ocs_q_reg <= ocs_byte;
      lds_q_reg <= lds_byte;
    end
  end

  assign global_fault_status = gs_q_reg;
  assign output_overcurrent_clip_status = ocs_q_reg;
  assign output_load_diag_status = lds_q_reg;

endmodule

`default_nettype wire

// ---- afs_pkg.sv ----
/*
  Shared constants of the amplifier fault and diagnostic status block: register
  pointers, field positions, reset values and the serial bus framing.
  Assumes the including code reaches every name as afs_pkg::name.
*/
`default_nettype none

package afs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int OUTS = 4;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_GLOBAL_FAULT_STATUS = 8'h10;
  localparam logic [7:0] PTR_OUTPUT_OVERCURRENT_CLIP_STATUS = 8'h11;
  localparam logic [7:0] PTR_OUTPUT_LOAD_DIAG_STATUS = 8'h12;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // global status field positions
  // ----------------------------------------------------------------
  localparam int GS_UNUSED = 7;
  localparam int GS_THERMAL_SHUTDOWN = 6;
  localparam int GS_THERMAL_WARNING = 5;
  localparam int GS_SUPPLY_OVER = 4;
  localparam int GS_SUPPLY_UNDER = 3;
  localparam int GS_ANY_OVERCURRENT = 2;
  localparam int GS_PUMP_HOLD_LOW = 1;
  localparam int GS_ANY_CLIP = 0;

  // per-output fields: upper nibble and lower nibble, output 3 at the top
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OC_LATCH_RESET = 4'hF;
  localparam logic PUMP_HOLD_RESET = 1'b1;
  localparam logic [3:0] LOAD_IDLE = 4'hF;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // serial bus framing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_BASE_DEFAULT = 7'h34;
  localparam int ADDR_SEL_W = 2;
  localparam logic RW_READ = 1'b1;

endpackage

`default_nettype wire

// ---- afs_sync.sv ----
/*
  Two flip-flop synchroniser bank for levels that enter from outside the clock
  domain. Assumes each bit is a slow level, not a word; bits may skew by a cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    stable_next = meta_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_reg <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      stable_reg <= stable_next;
    end
  end

  assign sync_out = stable_reg;

endmodule

`default_nettype wire

// ---- afs_status_chk.sv ----
/*
  Concurrent checks of the three status images against the detector inputs.
  Assumes a detector level that has held for eight cycles is settled in the
  images, which allows two sync stages plus the image and output registers.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_status_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic thermal_shutdown_det,
  input wire logic [3:0] warn_above_det,
  input wire logic [1:0] warn_temp_select,
  input wire logic supply_over_det,
  input wire logic supply_under_det,
  input wire logic pump_hold_below_det,
  input wire logic pump_hold_above_det,
  input wire logic [3:0] out_overcurrent_det,
  input wire logic [3:0] out_clip_det,
  input wire logic open_load_diag_active,
  input wire logic line_driver_select,
  input wire logic [3:0] res_above_speaker_det,
  input wire logic [3:0] res_above_line_det,
  input wire logic short_load_diag_active,
  input wire logic [3:0] load_current_det,
  input wire logic [7:0] global_fault_status,
  input wire logic [7:0] output_overcurrent_clip_status,
  input wire logic [7:0] output_load_diag_status
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_SPARE: assert property (global_fault_status[7] == 1'b0)
    else $error("global spare bit set");
  AST_TSD: assert property ($stable(thermal_shutdown_det) [*8] |->
    global_fault_status[6] == !thermal_shutdown_det) else $error("shutdown bit wrong");
  AST_WARN: assert property (($stable(warn_above_det) && $stable(warn_temp_select)) [*8]
    |-> global_fault_status[5] == !warn_above_det[warn_temp_select])
    else $error("warning bit wrong");
  AST_OVER: assert property ($stable(supply_over_det) [*8] |->
    global_fault_status[4] == !supply_over_det) else $error("overvoltage bit wrong");
  AST_UNDER: assert property ($stable(supply_under_det) [*8] |->
    global_fault_status[3] == !supply_under_det) else $error("undervoltage bit wrong");
  // global overcurrent is the and of the latched per-output bits
  AST_OCG: assert property (global_fault_status[2] == &output_overcurrent_clip_status[7:4])
    else $error("global overcurrent wrong");
  AST_OCSET: assert property ($stable(out_overcurrent_det) [*8] |->
    (output_overcurrent_clip_status[7:4] & out_overcurrent_det) == 4'h0)
    else $error("overcurrent not latched");
  AST_PLOW: assert property ((pump_hold_below_det && !pump_hold_above_det) [*8] |->
    !global_fault_status[1]) else $error("pump bit not low");
  // between the two levels the bit must keep whatever it had
  AST_PHOLD: assert property ((!pump_hold_below_det && !pump_hold_above_det) [*8] |->
    $stable(global_fault_status[1])) else $error("pump bit moved in band");
  AST_CLIP: assert property ($stable(out_clip_det) [*8] |->
    output_overcurrent_clip_status[3:0] == ~out_clip_det &&
    global_fault_status[0] == !(|out_clip_det)) else $error("clip bits wrong");
  AST_LDOK: assert property (($stable(res_above_speaker_det) && $stable(res_above_line_det)
    && $stable(line_driver_select) && $stable(open_load_diag_active)) [*8] |->
    output_load_diag_status[7:4] == (open_load_diag_active ?
    (line_driver_select ? res_above_line_det : res_above_speaker_det) : 4'hF))
    else $error("load okay bits wrong");
  AST_LOAD: assert property (($stable(load_current_det) && $stable(short_load_diag_active))
    [*8] |-> output_load_diag_status[3:0] == (short_load_diag_active ? ~load_current_det : 4'hF))
    else $error("load bits wrong");
endmodule

bind afs_status_top afs_status_chk i_chk (.core_clk(core_clk), .rstn(rstn),
  .thermal_shutdown_det(thermal_shutdown_det), .warn_above_det(warn_above_det),
  .warn_temp_select(warn_temp_select), .supply_over_det(supply_over_det),
  .supply_under_det(supply_under_det), .pump_hold_below_det(pump_hold_below_det),
  .pump_hold_above_det(pump_hold_above_det), .out_overcurrent_det(out_overcurrent_det),
  .out_clip_det(out_clip_det), .open_load_diag_active(open_load_diag_active),
  .line_driver_select(line_driver_select), .res_above_speaker_det(res_above_speaker_det),
  .res_above_line_det(res_above_line_det), .short_load_diag_active(short_load_diag_active),
  .load_current_det(load_current_det), .global_fault_status(global_fault_status),
  .output_overcurrent_clip_status(output_overcurrent_clip_status),
  .output_load_diag_status(output_load_diag_status));

`default_nettype wire

// ---- afs_host_model.sv ----
/*
  Two-wire serial host that reads and writes the status registers.
  Assumes an open-drain data line with a pull-up; the device pulls via dut_oe.
*/
`timescale 1ns/1ps
`default_nettype none

module afs_host_model (
  input wire logic core_clk,
  input wire logic dut_oe,
  output logic scl,
  output logic sda
);
  // ----------------------------------------------------------------
  // bus timing
  // ----------------------------------------------------------------
  localparam int Q = 8;
  logic drive_low;

  // idle bus is high on both lines
  initial begin
    scl = 1'b1;
    drive_low = 1'b0;
  end
  // wired and of both pullers, released line goes to the pull-up level
  assign sda = !(drive_low || dut_oe);

  task automatic wt();
    repeat (Q) @(posedge core_clk);
  endtask

  // data changes only while scl is low, sampled mid high phase
  task automatic put(input logic b, output logic s);
    drive_low <= !b;
    wt();
    scl <= 1'b1;
    wt();
    s = sda;
    wt();
    scl <= 1'b0;
    wt();
  endtask

  task automatic start();
    drive_low <= 1'b1;
    wt();
    scl <= 1'b0;
    wt();
  endtask

  task automatic stop();
    drive_low <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    drive_low <= 1'b0;
    wt();
  endtask

  // msb first, then the ninth clock reads the acknowledge
  task automatic send(input logic [7:0] b, inout logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) put(b[i], s);
    put(1'b1, s);
    nak = nak | s;
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat,
                    output logic nak);
    nak = 1'b0;
    start();
    send({dev, ~afs_pkg::RW_READ}, nak);
    send(ptr, nak);
    send(dat, nak);
    stop();
  endtask

  // pointer set by a write, then one byte read and refused with a nack
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
                    output logic nak);
    logic s;
    nak = 1'b0;
    start();
    send({dev, ~afs_pkg::RW_READ}, nak);
    send(ptr, nak);
    stop();
    start();
    send({dev, afs_pkg::RW_READ}, nak);
    for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
    put(1'b1, s);
    stop();
  endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
/*
  Testbench of the status registers: drives detector levels, compares the
  register images and serial reads with a reference model kept here.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic core_clk, rstn, scl, sda, oe, nak, pump;
  logic ts, so, su, pb, pa, ol, lsel, sl;
  logic [1:0] ws, asel;
  logic [3:0] wa, oc, cl, rs, rl, lc, oc_l;
  logic [7:0] gs, os, ld, d;
  logic [6:0] dev;
  int n_fail, comparisons, cyc;

  afs_status_top i_dut (.core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(oe), .addr_sel(asel), .thermal_shutdown_det(ts),
    .warn_above_det(wa), .warn_temp_select(ws), .supply_over_det(so),
    .supply_under_det(su), .pump_hold_below_det(pb), .pump_hold_above_det(pa),
    .out_overcurrent_det(oc), .out_clip_det(cl), .open_load_diag_active(ol),
    .line_driver_select(lsel), .res_above_speaker_det(rs), .res_above_line_det(rl),
    .short_load_diag_active(sl), .load_current_det(lc), .global_fault_status(gs),
    .output_overcurrent_clip_status(os), .output_load_diag_status(ld));
  afs_host_model i_host (.core_clk(core_clk), .dut_oe(oe), .scl(scl), .sda(sda));

  // ----------------------------------------------------------------
  // clock, timeout, reporting
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // whole run is about 9.2k cycles, so this only trips on a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // reference images, active-low indicators
  function automatic logic [7:0] e_gs();
    return {1'b0, !ts, !wa[ws], !so, !su, &oc_l, pump, !(|cl)};
  endfunction
  function automatic logic [7:0] e_os();
    return {oc_l, ~cl};
  endfunction
  function automatic logic [7:0] e_ld();
    return {ol ? (lsel ? rl : rs) : 4'hF, sl ? ~lc : 4'hF};
  endfunction

  // settle past the synchronisers, compare all images, end on an edge
  task automatic look();
    repeat (8) @(posedge core_clk);
    #1;
    chk("global", gs, e_gs());
    chk("overcurrent_clip", os, e_os());
    chk("load_diag", ld, e_ld());
    @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
    i_host.rd(dev, p, d, nak);
    chk("ack", {7'h0, nak}, 8'h00);
    chk("read", d, e);
  endtask

  task automatic pmp(input logic b, input logic a);
    pb <= b;
    pa <= a;
    pump = b ? 1'b0 : (a ? 1'b1 : pump);
    look();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {ts, so, su, pb, pa, ol, lsel, sl} = 8'h00;
    {wa, oc, cl, rs, rl, lc} = 24'h00_0000;
    ws = 2'h0;
    asel = 2'h2;
    dev = {afs_pkg::DEV_ADDR_BASE_DEFAULT[6:2], asel};
    oc_l = 4'hF;
    pump = 1'b1;
    rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    look();
    ts <= 1'b1;
    look();
    ts <= 1'b0;
    so <= 1'b1;
    look();
    so <= 1'b0;
    su <= 1'b1;
    look();
    su <= 1'b0;
    // every threshold choice, with the selected line alone and alone missing
    for (int i = 0; i < 4; i++) begin
      ws <= 2'(i);
      wa <= 4'(1 << i);
      look();
      wa <= ~4'(1 << i);
      look();
    end
    pmp(1'b1, 1'b0);
    pmp(1'b0, 1'b0);
    pmp(1'b0, 1'b1);
    pmp(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cl <= 4'(1 << i);
      look();
    end
    cl <= 4'h0;
    ol <= 1'b1;
    rs <= 4'h5;
    rl <= 4'hA;
    look();
    lsel <= 1'b1;
    look();
    ol <= 1'b0;
    sl <= 1'b1;
    lc <= 4'h3;
    look();
    sl <= 1'b0;
    oc <= 4'h4;
    oc_l = 4'hB;
    look();
    oc <= 4'h0;
    look();
    rdchk(afs_pkg::PTR_GLOBAL_FAULT_STATUS, e_gs());
    rdchk(afs_pkg::PTR_OUTPUT_OVERCURRENT_CLIP_STATUS, e_os());
    rdchk(afs_pkg::PTR_OUTPUT_LOAD_DIAG_STATUS, e_ld());
    rdchk(8'h20, afs_pkg::UNMAPPED_READ);
    i_host.rd(dev ^ 7'h01, afs_pkg::PTR_GLOBAL_FAULT_STATUS, d, nak);
    chk("foreign address nack", {7'h0, nak}, 8'h01);
    // writes to read-only bits and zeros to the latch change nothing
    i_host.wr(dev, afs_pkg::PTR_GLOBAL_FAULT_STATUS, 8'h00, nak);
    i_host.wr(dev, afs_pkg::PTR_OUTPUT_OVERCURRENT_CLIP_STATUS, 8'h0F, nak);
    look();
    i_host.wr(dev, afs_pkg::PTR_OUTPUT_OVERCURRENT_CLIP_STATUS, 8'h40, nak);
    oc_l = 4'hF;
    look();
    oc <= 4'h9;
    oc_l = 4'h6;
    look();
    oc <= 4'h0;
    rstn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    oc_l = 4'hF;
    look();
    finish_test();
  end
endmodule

`default_nettype wire
